// [hdl/swcb_pkg.sv]
package swcb_pkg;

	////////////////////////////////////////////////////////////////////////
	// Sizes
	localparam int unsigned SWCB_BLOCKS  = 4;
	localparam int unsigned SWCB_ADDR_W  = 8;
	localparam int unsigned SWCB_DATA_W  = 8;
	localparam int unsigned SWCB_CAP_W   = 5;
	localparam int unsigned SWCB_SYNC_N  = 3;

	////////////////////////////////////////////////////////////////////////
	// Register offsets, same in bank 0 and bank 1
	localparam logic [SWCB_ADDR_W-1:0] SWCB_B11_CONTROL2_OFS = 8'h86;
	localparam logic [SWCB_ADDR_W-1:0] SWCB_B13_CONTROL2_OFS = 8'h8e;
	localparam logic [SWCB_ADDR_W-1:0] SWCB_B20_CONTROL2_OFS = 8'h92;
	localparam logic [SWCB_ADDR_W-1:0] SWCB_B22_CONTROL2_OFS = 8'h9a;
	localparam logic [SWCB_ADDR_W-1:0] SWCB_CONTROL2_OFS [SWCB_BLOCKS] = '{
		SWCB_B11_CONTROL2_OFS,
		SWCB_B13_CONTROL2_OFS,
		SWCB_B20_CONTROL2_OFS,
		SWCB_B22_CONTROL2_OFS
	};

	////////////////////////////////////////////////////////////////////////
	// Field positions and reset value
	localparam int unsigned SWCB_COL_BUS_EN_BIT  = 7;
	localparam int unsigned SWCB_CMP_BUS_EN_BIT  = 6;
	localparam int unsigned SWCB_OFS_NULL_BIT    = 5;
	localparam int unsigned SWCB_CAP_MSB         = 4;
	localparam int unsigned SWCB_CAP_LSB         = 0;
	localparam logic [SWCB_DATA_W-1:0] SWCB_CONTROL2_RESET = 8'h00;

	////////////////////////////////////////////////////////////////////////
	// Timing: length of the late part of the second phase, in cycles
	localparam int unsigned SWCB_LATE_CYCLES = 2;
	localparam int unsigned SWCB_PHASE_CNT_W = 8;

	////////////////////////////////////////////////////////////////////////
	// Phase tracker states
	typedef enum logic [1:0] {
		SWCB_PH_NONE,
		SWCB_PH_FIRST,
		SWCB_PH_SECOND
	} swcb_phase_t;

endpackage : swcb_pkg

// [hdl/swcb_regfile.sv]
`timescale 1ns/1ns
module swcb_regfile
	import swcb_pkg::*;
#(
	parameter int unsigned WORDS = 4,
	parameter int unsigned WIDTH = 8,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	input  wire logic                       clk_i,
	input  wire logic                       reset_i,
	input  wire logic                       write_i,
	input  wire logic [$clog2(WORDS)-1:0]   windex_i,
	input  wire logic [WIDTH-1:0]           wdata_i,
	input  wire logic                       read_i,
	input  wire logic                       rhit_i,
	input  wire logic [$clog2(WORDS)-1:0]   rindex_i,
	output logic      [WIDTH-1:0]           rdata_o,
	output logic      [WORDS-1:0][WIDTH-1:0] words_o
);

	logic [WORDS-1:0][WIDTH-1:0] mem;

	////////////////////////////////////////////////////////////////////////
	// Storage
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			mem <= {WORDS{RESET_VALUE}};
		end else if (write_i) begin
			mem[windex_i] <= wdata_i;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read data stand only in the cycle after the read strobe
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			rdata_o <= '0;
		end else if (read_i && rhit_i) begin
			rdata_o <= mem[rindex_i];
		end else begin
			rdata_o <= '0;
		end
	end

	assign words_o = mem;

endmodule : swcb_regfile

// [hdl/swcb_ctrl2.sv]
// Contract
// - Column bus enable clear: column drive off
// - Phase select 0: drive late second phase
// - Phase select 1: drive column bus always
// - Bit 6 gates comparator bus drive
// - Undriven comparator bus reads low
// - Latch comparator at first-phase rise, hold
// - Offset null clear: short off, branches opamp
// - Offset null set: short/ground first phase
// - Offset null modifies integrator feedback switch
// - Bits 4:0 give C capacitor units
// - Four registers, same in banks 0/1
// - Feedback switch: steady, or second phase
`timescale 1ns/1ns
module swcb_ctrl2
	import swcb_pkg::*;
#(
	parameter int unsigned LATE_CYCLES = SWCB_LATE_CYCLES,
	parameter int unsigned CNT_W       = SWCB_PHASE_CNT_W
) (
	input  wire logic                                  clk_i,
	input  wire logic                                  reset_i,
	input  wire logic [SWCB_ADDR_W-1:0]                reg_addr_i,
	input  wire logic                                  reg_bank_i,
	input  wire logic [SWCB_DATA_W-1:0]                reg_wdata_i,
	input  wire logic                                  reg_write_i,
	input  wire logic                                  reg_read_i,
	output logic      [SWCB_DATA_W-1:0]                reg_rdata_o,
	input  wire logic                                  first_clock_phase_i,
	input  wire logic                                  second_clock_phase_i,
	input  wire logic [SWCB_BLOCKS-1:0]                output_phase_select_i,
	input  wire logic [SWCB_BLOCKS-1:0]                integrator_feedback_switch_ctl_i,
	input  wire logic [SWCB_BLOCKS-1:0]                comparator_raw_i,
	output logic      [SWCB_BLOCKS-1:0]                column_bus_oe_o,
	output logic      [SWCB_BLOCKS-1:0]                comparator_bus_oe_o,
	output logic      [SWCB_BLOCKS-1:0]                comparator_bus_o,
	output logic      [SWCB_BLOCKS-1:0]                comparator_latched_o,
	output logic      [SWCB_BLOCKS-1:0]                shorting_switch_o,
	output logic      [SWCB_BLOCKS-1:0]                branch_to_ground_o,
	output logic      [SWCB_BLOCKS-1:0]                branch_to_opamp_o,
	output logic      [SWCB_BLOCKS-1:0]                integrator_fb_switch_o,
	output logic      [SWCB_BLOCKS-1:0][SWCB_CAP_W-1:0] c_branch_cap_size_o
);

	localparam int unsigned IDX_W = $clog2(SWCB_BLOCKS);
	localparam logic [CNT_W-1:0] LATE_CNT = CNT_W'(LATE_CYCLES);
	localparam logic [CNT_W-1:0] CNT_MAX  = {CNT_W{1'b1}};

	////////////////////////////////////////////////////////////////////////
	// Address decode
	logic [SWCB_BLOCKS-1:0] addr_hit;
	logic                   any_hit;
	logic [IDX_W-1:0]       hit_index;
	logic                   bank_ok;
	logic                   do_write;
	logic                   do_read;

	// Both banks reach the same four registers
	assign bank_ok = (reg_bank_i == 1'b0) || (reg_bank_i == 1'b1);

	genvar gi;
	generate
		for (gi = 0; gi < SWCB_BLOCKS; gi++) begin : g_decode
			assign addr_hit[gi] = (reg_addr_i == SWCB_CONTROL2_OFS[gi]);
		end
	endgenerate

	assign any_hit = |addr_hit;

	always_comb begin
		hit_index = '0;
		for (int i = 0; i < SWCB_BLOCKS; i++) begin
			if (addr_hit[i]) begin
				hit_index = IDX_W'(i);
			end
		end
	end

	assign do_write = reg_write_i && any_hit && bank_ok;
	assign do_read  = reg_read_i && bank_ok;

	////////////////////////////////////////////////////////////////////////
	// Register storage
	logic [SWCB_BLOCKS-1:0][SWCB_DATA_W-1:0] control2;

	swcb_regfile #(
		.WORDS       (SWCB_BLOCKS),
		.WIDTH       (SWCB_DATA_W),
		.RESET_VALUE (SWCB_CONTROL2_RESET)
	) u_regfile (
		.clk_i    (clk_i),
		.reset_i  (reset_i),
		.write_i  (do_write),
		.windex_i (hit_index),
		.wdata_i  (reg_wdata_i),
		.read_i   (do_read),
		.rhit_i   (any_hit),
		.rindex_i (hit_index),
		.rdata_o  (reg_rdata_o),
		.words_o  (control2)
	);

	////////////////////////////////////////////////////////////////////////
	// Field extraction
	logic [SWCB_BLOCKS-1:0] col_bus_en;
	logic [SWCB_BLOCKS-1:0] cmp_bus_en;
	logic [SWCB_BLOCKS-1:0] ofs_null_en;

	generate
		for (gi = 0; gi < SWCB_BLOCKS; gi++) begin : g_fields
			assign col_bus_en[gi]  = control2[gi][SWCB_COL_BUS_EN_BIT];
			assign cmp_bus_en[gi]  = control2[gi][SWCB_CMP_BUS_EN_BIT];
			assign ofs_null_en[gi] = control2[gi][SWCB_OFS_NULL_BIT];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Phase tracker
	swcb_phase_t phase;
	swcb_phase_t next_phase;
	logic        phase_one;
	logic        phase_two;
	logic        first_q;
	logic        first_rise;

	// Only a clean, non-overlapped phase counts as active
	always_comb begin
		next_phase = SWCB_PH_NONE;
		if (first_clock_phase_i && !second_clock_phase_i) begin
			next_phase = SWCB_PH_FIRST;
		end else if (second_clock_phase_i && !first_clock_phase_i) begin
			next_phase = SWCB_PH_SECOND;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			phase <= SWCB_PH_NONE;
		end else begin
			phase <= next_phase;
		end
	end

	always_comb begin
		phase_one = 1'b0;
		phase_two = 1'b0;
		case (next_phase)
			SWCB_PH_FIRST: begin
				phase_one = 1'b1;
			end
			SWCB_PH_SECOND: begin
				phase_two = 1'b1;
			end
			default: begin
				phase_one = 1'b0;
				phase_two = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			first_q <= 1'b0;
		end else begin
			first_q <= first_clock_phase_i;
		end
	end

	assign first_rise = first_clock_phase_i && !first_q;

	////////////////////////////////////////////////////////////////////////
	// Second phase length, measured to find its final portion
	logic [CNT_W-1:0] phase2_cnt;
	logic [CNT_W-1:0] phase2_len;
	logic [CNT_W-1:0] next_phase2_cnt;
	logic             phase2_late;

	assign next_phase2_cnt = (phase2_cnt == CNT_MAX) ? CNT_MAX
		: phase2_cnt + CNT_W'(1);

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			phase2_cnt <= '0;
		end else if (phase_two) begin
			phase2_cnt <= next_phase2_cnt;
		end else begin
			phase2_cnt <= '0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			phase2_len <= '0;
		end else if (!phase_two && phase == SWCB_PH_SECOND) begin
			phase2_len <= phase2_cnt;
		end
	end

	// Until one whole second phase has been seen the late part is unknown
	always_comb begin
		phase2_late = 1'b0;
		if (phase_two && phase2_len != '0) begin
			if (phase2_len <= LATE_CNT) begin
				phase2_late = 1'b1;
			end else if (next_phase2_cnt > phase2_len - LATE_CNT) begin
				phase2_late = 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Comparator input synchronisers and phase latch
	logic [SWCB_BLOCKS-1:0] cmp_s1;
	logic [SWCB_BLOCKS-1:0] cmp_s2;
	logic [SWCB_BLOCKS-1:0] cmp_s3;
	logic [SWCB_BLOCKS-1:0] cmp_clean;
	logic [SWCB_BLOCKS-1:0] cmp_latch;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			cmp_s1 <= '0;
			cmp_s2 <= '0;
			cmp_s3 <= '0;
		end else begin
			cmp_s1 <= comparator_raw_i;
			cmp_s2 <= cmp_s1;
			cmp_s3 <= cmp_s2;
		end
	end

	generate
		for (gi = 0; gi < SWCB_BLOCKS; gi++) begin : g_cmp
			always_ff @(posedge clk_i) begin
				if (reset_i) begin
					cmp_clean[gi] <= 1'b0;
				end else if (cmp_s2[gi] == cmp_s3[gi]) begin
					cmp_clean[gi] <= cmp_s3[gi];
				end
			end

			// Value held across the following second phase
			always_ff @(posedge clk_i) begin
				if (reset_i) begin
					cmp_latch[gi] <= 1'b0;
				end else if (first_rise) begin
					cmp_latch[gi] <= cmp_clean[gi];
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Switch decode per block
	logic [SWCB_BLOCKS-1:0] next_col_oe;
	logic [SWCB_BLOCKS-1:0] next_cmp_oe;
	logic [SWCB_BLOCKS-1:0] next_cmp_bus;
	logic [SWCB_BLOCKS-1:0] next_short;
	logic [SWCB_BLOCKS-1:0] next_ground;
	logic [SWCB_BLOCKS-1:0] next_opamp;
	logic [SWCB_BLOCKS-1:0] next_fb;

	generate
		for (gi = 0; gi < SWCB_BLOCKS; gi++) begin : g_switch
			always_comb begin
				if (!col_bus_en[gi]) begin
					next_col_oe[gi] = 1'b0;
				end else if (output_phase_select_i[gi]) begin
					next_col_oe[gi] = 1'b1;
				end else begin
					next_col_oe[gi] = phase2_late;
				end
			end

			always_comb begin
				next_cmp_oe[gi]  = cmp_bus_en[gi];
				// An undriven comparator bus is pulled low
				next_cmp_bus[gi] = cmp_bus_en[gi] && cmp_latch[gi];
			end

			always_comb begin
				if (!ofs_null_en[gi]) begin
					next_short[gi]  = 1'b0;
					next_ground[gi] = 1'b0;
					next_opamp[gi]  = 1'b1;
				end else begin
					next_short[gi]  = phase_one;
					next_ground[gi] = phase_one;
					next_opamp[gi]  = phase_two;
				end
			end

			always_comb begin
				if (!integrator_feedback_switch_ctl_i[gi]) begin
					next_fb[gi] = 1'b0;
				end else if (!ofs_null_en[gi]) begin
					next_fb[gi] = 1'b1;
				end else begin
					next_fb[gi] = phase_two;
				end
			end

			assign c_branch_cap_size_o[gi] =
				control2[gi][SWCB_CAP_MSB:SWCB_CAP_LSB];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Registered switch outputs, free of decode glitches
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			column_bus_oe_o <= '0;
		end else begin
			column_bus_oe_o <= next_col_oe;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			comparator_bus_oe_o  <= '0;
			comparator_bus_o     <= '0;
			comparator_latched_o <= '0;
		end else begin
			comparator_bus_oe_o  <= next_cmp_oe;
			comparator_bus_o     <= next_cmp_bus;
			comparator_latched_o <= cmp_latch;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			shorting_switch_o  <= '0;
			branch_to_ground_o <= '0;
			branch_to_opamp_o  <= '0;
		end else begin
			shorting_switch_o  <= next_short;
			branch_to_ground_o <= next_ground;
			branch_to_opamp_o  <= next_opamp;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			integrator_fb_switch_o <= '0;
		end else begin
			integrator_fb_switch_o <= next_fb;
		end
	end

endmodule : swcb_ctrl2

// [verification/swcb_ctrl2_props.sv]
`timescale 1ns/1ns
module swcb_ctrl2_props
	import swcb_pkg::*;
(
	input wire logic             clk_i,
	input wire logic             reset_i,
	input wire logic [7:0]       reg_addr_i,
	input wire logic [7:0]       reg_wdata_i,
	input wire logic             reg_write_i,
	input wire logic             reg_read_i,
	input wire logic [7:0]       reg_rdata_o,
	input wire logic             first_clock_phase_i,
	input wire logic             second_clock_phase_i,
	input wire logic [3:0]       output_phase_select_i,
	input wire logic [3:0]       integrator_feedback_switch_ctl_i,
	input wire logic [3:0]       column_bus_oe_o,
	input wire logic [3:0]       comparator_bus_oe_o,
	input wire logic [3:0]       comparator_bus_o,
	input wire logic [3:0]       comparator_latched_o,
	input wire logic [3:0]       shorting_switch_o,
	input wire logic [3:0]       branch_to_ground_o,
	input wire logic [3:0]       branch_to_opamp_o,
	input wire logic [3:0]       integrator_fb_switch_o,
	input wire logic [3:0][4:0]  c_branch_cap_size_o
);
	////////////////////////////////////////////////////////////////////////
	// Shadow of the four registers and phase decode
	logic [7:0]      sh [4];
	logic [7:0]      rdx;
	logic [3:0]      nul, col, cmp;
	logic [3:0][4:0] cap;
	logic            f1, f2, fr, fq;
	logic [1:0]      age;
	assign f1 = first_clock_phase_i & ~second_clock_phase_i;
	assign f2 = second_clock_phase_i & ~first_clock_phase_i;
	assign fr = first_clock_phase_i & ~fq;
	always_ff @(posedge clk_i) begin
		fq <= first_clock_phase_i;
	end
	// Hold checks off until the pipeline has left reset
	always_ff @(posedge clk_i) begin
		age <= reset_i ? 2'h0 : age + 2'(age != 2'h3);
	end
	always_ff @(posedge clk_i) begin
		for (int i = 0; i < 4; i++) begin
			if (reset_i)
				sh[i] <= SWCB_CONTROL2_RESET;
			else if (reg_write_i && reg_addr_i == SWCB_CONTROL2_OFS[i])
				sh[i] <= reg_wdata_i;
		end
	end
	always_comb begin
		rdx = 8'h00;
		for (int i = 0; i < 4; i++) begin
			col[i] = sh[i][7];
			cmp[i] = sh[i][6];
			nul[i] = sh[i][5];
			cap[i] = sh[i][4:0];
			if (reg_addr_i == SWCB_CONTROL2_OFS[i])
				rdx = sh[i];
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Properties
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i || age != 2'h3);
	property p_col_off;
		1 |=> (column_bus_oe_o & ~$past(col)) == 4'h0;
	endproperty
	a_col_off: assert property (p_col_off) else $error("column drive on");
	property p_col_late;
		1 |=> (column_bus_oe_o & ~$past(output_phase_select_i)
			& ~{4{$past(f2)}}) == 4'h0;
	endproperty
	a_col_late: assert property (p_col_late) else $error("early drive");
	property p_col_cont;
		1 |=> ($past(col & output_phase_select_i) & ~column_bus_oe_o) == 4'h0;
	endproperty
	a_col_cont: assert property (p_col_cont) else $error("drive gap");
	property p_cmp_oe;
		1 |=> comparator_bus_oe_o == $past(cmp);
	endproperty
	a_cmp_oe: assert property (p_cmp_oe) else $error("comparator oe");
	property p_cmp_low;
		comparator_bus_o == (comparator_latched_o & comparator_bus_oe_o);
	endproperty
	a_cmp_low: assert property (p_cmp_low) else $error("comparator bus");
	property p_latch_hold;
		$changed(comparator_latched_o) |-> $past(fr) || $past(fr, 2);
	endproperty
	a_latch_hold: assert property (p_latch_hold) else $error("latch moved");
	property p_null_off;
		1 |=> ($past(~nul) & (shorting_switch_o | branch_to_ground_o
			| ~branch_to_opamp_o)) == 4'h0;
	endproperty
	a_null_off: assert property (p_null_off) else $error("null off");
	property p_null_on;
		1 |=> shorting_switch_o == $past(nul & {4{f1}})
			&& branch_to_ground_o == $past(nul & {4{f1}})
			&& ($past(nul & {4{f2}}) & ~branch_to_opamp_o) == 4'h0;
	endproperty
	a_null_on: assert property (p_null_on) else $error("null on");
	property p_fb;
		1 |=> integrator_fb_switch_o == $past(integrator_feedback_switch_ctl_i
			& (~nul | {4{f2}}));
	endproperty
	a_fb: assert property (p_fb) else $error("feedback switch");
	property p_cap;
		c_branch_cap_size_o == cap;
	endproperty
	a_cap: assert property (p_cap) else $error("cap size");
	property p_read;
		reg_read_i |=> reg_rdata_o == $past(rdx);
	endproperty
	a_read: assert property (p_read) else $error("read data");
	c_rw: cover property (reg_write_i ##[1:2] reg_read_i);
	c_late: cover property (|(column_bus_oe_o & ~output_phase_select_i));
	c_latch: cover property ($changed(comparator_latched_o));
endmodule : swcb_ctrl2_props

// [verification/test_swcb_ctrl2.sv]
`timescale 1ns/1ns
module test_swcb_ctrl2 import swcb_pkg::*;;
	logic            clk_i = 0, reset_i = 1, wr = 0, rd = 0, bank = 0;
	logic            p1 = 0, p2 = 0;
	logic [3:0]      ph = 4'h0, sel = 4'h0, fbc = 4'h0, raw = 4'h0, late;
	logic [7:0]      addr = 8'h00, wdata = 8'h00, rdata;
	logic [3:0]      col_oe, cmp_oe, cmp_bus, latched, shrt, gnd, opa, fb;
	logic [3:0][4:0] cap;
	logic [7:0]      mdl [4] = '{4{8'h00}};
	logic [7:0]      cv [3] = '{8'h00, 8'he0, 8'hb3};
	logic [3:0]      sv [3] = '{4'h0, 4'hf, 4'h5};
	logic [3:0]      fv [3] = '{4'hf, 4'h5, 4'ha};
	int              error_cnt = 0, total_checks = 0;

	swcb_ctrl2 dut (
		.clk_i(clk_i), .reset_i(reset_i), .reg_addr_i(addr),
		.reg_bank_i(bank), .reg_wdata_i(wdata), .reg_write_i(wr),
		.reg_read_i(rd), .reg_rdata_o(rdata), .first_clock_phase_i(p1),
		.second_clock_phase_i(p2), .output_phase_select_i(sel),
		.integrator_feedback_switch_ctl_i(fbc), .comparator_raw_i(raw),
		.column_bus_oe_o(col_oe), .comparator_bus_oe_o(cmp_oe),
		.comparator_bus_o(cmp_bus), .comparator_latched_o(latched),
		.shorting_switch_o(shrt), .branch_to_ground_o(gnd),
		.branch_to_opamp_o(opa), .integrator_fb_switch_o(fb),
		.c_branch_cap_size_o(cap)
	);

	always #2 clk_i = ~clk_i;
	// Non-overlapping phases: first 6 cycles, gap 2, second 6, gap 2
	always @(posedge clk_i) begin
		ph <= ph + 4'h1;
		p1 <= ph < 4'h6;
		p2 <= ph >= 4'h8 && ph < 4'he;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		for (int i = 0; i < 4; i++)
			if (a == SWCB_CONTROL2_OFS[i])
				mdl[i] = d;
		@(posedge clk_i);
		wr <= 1'b0;
	endtask : wreg
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_i);
		rd <= 1'b0;
		#1 chk(rdata, exp);
	endtask : rchk
	// Compare every switch output against the phases of the cycle before
	task automatic sweep(input int n);
		logic       q1, q2, f1, f2;
		logic [3:0] nu, en, e6;
		#1;
		q1 = p1;
		q2 = p2;
		for (int i = 0; i < 4; i++) begin
			nu[i] = mdl[i][5];
			en[i] = mdl[i][7];
			e6[i] = mdl[i][6];
		end
		repeat (n) begin
			@(posedge clk_i);
			#1;
			f1 = q1 & ~q2;
			f2 = q2 & ~q1;
			chk(shrt, nu & {4{f1}});
			chk(gnd, nu & {4{f1}});
			chk(opa | nu, 4'hf);
			chk(opa & nu & {4{f2}}, nu & {4{f2}});
			chk(fb, fbc & (~nu | {4{f2}}));
			chk(col_oe & ~en, 4'h0);
			chk(col_oe & sel, en & sel);
			chk(col_oe & ~sel & {4{~f2}}, 4'h0);
			chk(cmp_oe, e6);
			late = late | (col_oe & ~sel);
			q1 = p1;
			q2 = p2;
		end
	endtask : sweep
	task automatic close_out();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : close_out

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(posedge clk_i);
		reset_i <= 1'b0;
		for (int i = 0; i < 4; i++)
			rchk(SWCB_CONTROL2_OFS[i], SWCB_CONTROL2_RESET);
		rchk(8'h87, 8'h00);
		wreg(8'h85, 8'hff);
		for (int i = 0; i < 4; i++)
			wreg(SWCB_CONTROL2_OFS[i], 8'h5a + 8'(i));
		bank <= 1'b1;
		for (int i = 0; i < 4; i++)
			rchk(SWCB_CONTROL2_OFS[i], 8'h5a + 8'(i));
		@(posedge clk_i);
		bank <= 1'b0;
		for (int v = 0; v < 32; v++) begin
			wreg(SWCB_CONTROL2_OFS[v % 4], 8'(v));
			#1 chk({3'h0, cap[v % 4]}, 8'(v));
		end
		for (int k = 0; k < 3; k++) begin
			@(posedge clk_i);
			sel <= sv[k];
			fbc <= fv[k];
			for (int i = 0; i < 4; i++)
				wreg(SWCB_CONTROL2_OFS[i], cv[k] ^ 8'(i));
			late = 4'h0;
			sweep(32);
			chk(late, {4{cv[k][7]}} & ~sv[k]);
		end
		wreg(SWCB_CONTROL2_OFS[0], 8'h40);
		wreg(SWCB_CONTROL2_OFS[1], 8'h40);
		raw <= 4'ha;
		repeat (40) @(posedge clk_i);
		#1 chk(latched, 4'ha);
		chk(cmp_bus, 4'h2);
		// Start from the rise of a second phase, well before the next latch
		for (int t = 0; t < 20 && p2; t++)
			@(posedge clk_i) #1;
		for (int t = 0; t < 20 && !p2; t++)
			@(posedge clk_i) #1;
		@(posedge clk_i);
		raw <= 4'h5;
		repeat (4) @(posedge clk_i);
		#1 chk(latched, 4'ha);
		repeat (20) @(posedge clk_i);
		#1 chk(latched, 4'h5);
		chk(cmp_bus, 4'h1);
		close_out();
	end
	initial begin
		#100000;
		error_cnt++;
		close_out();
	end
endmodule : test_swcb_ctrl2

bind swcb_ctrl2 swcb_ctrl2_props u_props (
	.clk_i, .reset_i, .reg_addr_i, .reg_wdata_i, .reg_write_i,
	.reg_read_i, .reg_rdata_o, .first_clock_phase_i, .second_clock_phase_i,
	.output_phase_select_i, .integrator_feedback_switch_ctl_i,
	.column_bus_oe_o, .comparator_bus_oe_o, .comparator_bus_o,
	.comparator_latched_o, .shorting_switch_o, .branch_to_ground_o,
	.branch_to_opamp_o, .integrator_fb_switch_o, .c_branch_cap_size_o
);
